// ---- rtl/sync_ctrl.sv ----
// Sync word payload selection and SYNC~ request filter with register port
module sync_ctrl #(
    parameter int CNT_W = 6                                  // Low run counter width
) (
    input  wire logic                                  clock_in,
    input  wire logic                                  rst_in,
    input  wire logic [sync_ctrl_pkg::ADDR_W-1:0]      addr_in,
    input  wire logic [7:0]                            wdata_in,
    input  wire logic                                  wr_in,
    input  wire logic                                  rd_in,
    output logic      [7:0]                            rdata_out,
    input  wire logic                                  sync_n_in,
    input  wire logic                                  mb_start_in,
    input  wire logic [11:0]                           crc_in,
    input  wire logic [11:0]                           fec_in,
    output logic      [sync_ctrl_pkg::SYNC_WORD_BITS-1:0] sync_word_out,
    output logic                                       sync_word_valid_out,
    output logic                                       sync_request_out,
    output logic                                       link_enable_out
);

    // Register state
    logic [1:0]        sync_word_payload_mode_r;            // Payload mode field
    logic [4:0]        sync_request_low_count_r;            // Threshold field
    logic              link_enable_r;                       // Link enable
    logic              link_format_mode_r;                  // High selects 64B/66B
    logic              sync_s1_r;                           // Synchroniser first stage
    logic              sync_s2_r;                           // Synchroniser second stage
    logic [CNT_W-1:0]  low_run_r;                           // Consecutive low samples
    logic              request_r;                           // Request held
    logic              error_seen_r;                        // Short low run seen
    logic [7:0]        rdata_r;                             // Read data
    logic [sync_ctrl_pkg::SYNC_WORD_BITS-1:0] sync_word_r;  // Assembled sync word
    logic              sync_word_valid_r;                   // Sync word strobe
    sync_ctrl_pkg::payload_e payload;                       // Effective payload
    logic [11:0]       payload_bits;                        // Selected 12 payload bits
    logic              run_reached;                         // Low run long enough
    logic              run_qualifies;                       // Current low sample completes run
    logic              status_clear;                        // Software clears the error flag

    // Register writes
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            sync_word_payload_mode_r <= sync_ctrl_pkg::SYNC_WORD_MODE_RST[1:0];
            sync_request_low_count_r <= sync_ctrl_pkg::SYNC_REQUEST_LOW_COUNT_RST[4:0];
            link_enable_r            <= 1'b0;
            link_format_mode_r       <= 1'b1;
        end else if (wr_in) begin
            case (addr_in)
                sync_ctrl_pkg::SYNC_WORD_MODE_A: begin
                    // Upper bits are dropped; software keeps them zero
                    sync_word_payload_mode_r <= wdata_in[sync_ctrl_pkg::MODE_LSB +: 2];
                end
                sync_ctrl_pkg::SYNC_REQUEST_LOW_COUNT_A: begin
                    sync_request_low_count_r <= wdata_in[sync_ctrl_pkg::THRESH_LSB +: 5];
                end
                sync_ctrl_pkg::LINK_CTRL_A: begin
                    link_enable_r      <= wdata_in[sync_ctrl_pkg::ENABLE_BIT];
                    link_format_mode_r <= wdata_in[sync_ctrl_pkg::FORMAT_BIT];
                end
                default: begin
                    // Unmapped write ignored
                end
            endcase
        end
    end

    // Register reads, data one cycle after the strobe
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rdata_r <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                sync_ctrl_pkg::SYNC_WORD_MODE_A: rdata_r <= {6'h00, sync_word_payload_mode_r};
                sync_ctrl_pkg::SYNC_REQUEST_LOW_COUNT_A:    rdata_r <= {3'h0, sync_request_low_count_r};
                sync_ctrl_pkg::LINK_CTRL_A:      rdata_r <= {6'h00, link_format_mode_r,
                                                             link_enable_r};
                sync_ctrl_pkg::SYNC_STATUS_A:    rdata_r <= {5'h00, error_seen_r, request_r,
                                                             sync_s2_r};
                default:                         rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // Two-flop synchroniser for the SYNC~ pin, one sample per link clock
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            sync_s1_r <= 1'b1;
            sync_s2_r <= 1'b1;
        end else begin
            sync_s1_r <= sync_n_in;
            sync_s2_r <= sync_s1_r;
        end
    end

    // Low run length against threshold plus one. One bit wider than the
    // counter so a saturated count of 63 plus one cannot wrap to zero.
    function automatic logic run_long_enough(
        input logic [CNT_W:0] lows,                         // Low samples in the run
        input logic [4:0]     thresh                        // Threshold field
    );
        logic [CNT_W:0] need;                               // Samples a request needs
        need = (CNT_W+1)'(thresh) + (CNT_W+1)'(1);
        return lows >= need;
    endfunction : run_long_enough

    // Completed run long enough; a shorter one is an error report
    assign run_reached   = run_long_enough({1'b0, low_run_r}, sync_request_low_count_r);

    // Run counting the low sample now in the second stage as one more
    assign run_qualifies = run_long_enough({1'b0, low_run_r} + (CNT_W+1)'(1),
                                           sync_request_low_count_r);

    // Software write of one to the error bit of the status register
    assign status_clear  = wr_in && (addr_in == sync_ctrl_pkg::SYNC_STATUS_A) && wdata_in[2];

    // Consecutive-low counter, saturating
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            low_run_r <= '0;
        end else if (sync_s2_r) begin
            low_run_r <= '0;
        end else if (!(&low_run_r)) begin
            low_run_r <= low_run_r + CNT_W'(1);
        end
    end

    // Request held while the long low run lasts
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            request_r <= 1'b0;
        end else begin
            request_r <= link_enable_r && !sync_s2_r && run_qualifies;
        end
    end

    // Short low run flagged as an error report, otherwise no action
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            error_seen_r <= 1'b0;
        end else if (sync_s2_r && low_run_r != '0 && !run_reached) begin
            error_seen_r <= 1'b1;
        end else if (status_clear) begin
            error_seen_r <= 1'b0;
        end
    end

    // Effective payload; mode ignored in 8B/10B formats
    always_comb begin
        if (!link_format_mode_r) begin
            payload = sync_ctrl_pkg::PAY_NONE;
        end else begin
            case (sync_word_payload_mode_r)
                sync_ctrl_pkg::PAYLOAD_CRC12: payload = sync_ctrl_pkg::PAY_CRC;
                sync_ctrl_pkg::PAYLOAD_FEC:   payload = sync_ctrl_pkg::PAY_FEC;
                default:                      payload = sync_ctrl_pkg::PAY_CRC;
            endcase
        end
    end

    // Payload bit selection
    always_comb begin
        case (payload)
            sync_ctrl_pkg::PAY_CRC: payload_bits = crc_in;
            sync_ctrl_pkg::PAY_FEC: payload_bits = fec_in;
            default:                payload_bits = 12'h000;
        endcase
    end

    // Sync word built once per multiblock, commands zero
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            sync_word_r       <= '0;
            sync_word_valid_r <= 1'b0;
        end else begin
            sync_word_valid_r <= mb_start_in && link_enable_r && link_format_mode_r;
            if (mb_start_in) begin
                sync_word_r <= '0;
                sync_word_r[11:0] <= payload_bits;
            end
        end
    end

    assign rdata_out           = rdata_r;
    assign sync_word_out       = sync_word_r;
    assign sync_word_valid_out = sync_word_valid_r;
    assign sync_request_out    = request_r;
    assign link_enable_out     = link_enable_r;

    // Assertions guarding the register, filter and sync word logic
    // All but the reset checks are masked while reset is high

    // Threshold comes out of reset at three
    a_thresh_reset_val: assert property (@(posedge clock_in)
        $fell(rst_in) |-> sync_request_low_count_r == sync_ctrl_pkg::SYNC_REQUEST_LOW_COUNT_RST[4:0])
        else $error("threshold not three after reset");

    // Mode comes out of reset selecting CRC-12
    a_mode_reset_val: assert property (@(posedge clock_in)
        $fell(rst_in) |-> sync_word_payload_mode_r == sync_ctrl_pkg::SYNC_WORD_MODE_RST[1:0])
        else $error("mode not zero after reset");

    // A request needs an unbroken low run of threshold plus one samples
    a_request_needs_run: assert property (@(posedge clock_in) disable iff (rst_in)
        sync_request_out |-> $past(link_enable_r) && !$past(sync_s2_r)
            && ($past(low_run_r) >= CNT_W'($past(sync_request_low_count_r))))
        else $error("request without long low run");

    // Threshold zero: one low sample is enough
    a_zero_thresh_fast: assert property (@(posedge clock_in) disable iff (rst_in)
        (link_enable_r && sync_request_low_count_r == 5'h00 && !sync_s1_r && sync_s2_r)
        ##1 (link_enable_r && !sync_s2_r) |=> sync_request_out)
        else $error("request late at threshold zero");

    // A high sample restarts the run and drops the request
    a_high_clears_run: assert property (@(posedge clock_in) disable iff (rst_in)
        sync_s2_r |=> low_run_r == '0 && !sync_request_out)
        else $error("low run not restarted");

    // No request while the link is disabled
    a_request_gated: assert property (@(posedge clock_in) disable iff (rst_in)
        !link_enable_r |=> !sync_request_out)
        else $error("request while link disabled");

    // A full counter holds rather than wrapping back to short
    a_run_saturates: assert property (@(posedge clock_in) disable iff (rst_in)
        (&low_run_r) && !sync_s2_r |=> &low_run_r)
        else $error("low run counter wrapped");

    // A single low sample under a nonzero threshold is an error report
    a_short_run_error: assert property (@(posedge clock_in) disable iff (rst_in)
        (sync_s2_r && low_run_r == CNT_W'(1) && sync_request_low_count_r != 5'h00)
        |=> error_seen_r && !sync_request_out)
        else $error("short run not classed as error");

    // An error report in the clearing cycle is kept
    a_error_set_wins: assert property (@(posedge clock_in) disable iff (rst_in)
        (status_clear && sync_s2_r && low_run_r != '0 && !run_reached)
        |=> error_seen_r)
        else $error("error report lost to clear");

    // A clear with no new report empties the error flag
    a_error_clears: assert property (@(posedge clock_in) disable iff (rst_in)
        (status_clear && !(sync_s2_r && low_run_r != '0 && !run_reached))
        |=> !error_seen_r)
        else $error("error flag not cleared");

    // A threshold write lands at its strobe
    a_thresh_write_lands: assert property (@(posedge clock_in) disable iff (rst_in)
        (wr_in && addr_in == sync_ctrl_pkg::SYNC_REQUEST_LOW_COUNT_A)
        |=> sync_request_low_count_r == $past(wdata_in[4:0]))
        else $error("threshold write lost");

    // A mode write lands at its strobe
    a_mode_write_lands: assert property (@(posedge clock_in) disable iff (rst_in)
        (wr_in && addr_in == sync_ctrl_pkg::SYNC_WORD_MODE_A)
        |=> sync_word_payload_mode_r == $past(wdata_in[1:0]))
        else $error("mode write lost");

    // A control write sets the link enable
    a_enable_write_lands: assert property (@(posedge clock_in) disable iff (rst_in)
        (wr_in && addr_in == sync_ctrl_pkg::LINK_CTRL_A)
        |=> link_enable_out == $past(wdata_in[sync_ctrl_pkg::ENABLE_BIT]))
        else $error("link enable write lost");

    // Mode read gives the field with reserved bits zero
    a_mode_reserved_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        (rd_in && addr_in == sync_ctrl_pkg::SYNC_WORD_MODE_A) |=> rdata_out[7:2] == 6'h00)
        else $error("mode reserved bits not zero");

    // Threshold read gives the field with reserved bits zero
    a_thresh_reserved_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        (rd_in && addr_in == sync_ctrl_pkg::SYNC_REQUEST_LOW_COUNT_A) |=> rdata_out[7:5] == 3'h0)
        else $error("threshold reserved bits not zero");

    // Status read keeps its unused bits zero
    a_status_reserved_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        (rd_in && addr_in == sync_ctrl_pkg::SYNC_STATUS_A) |=> rdata_out[7:3] == 5'h00)
        else $error("status unused bits not zero");

    // Control read keeps its unused bits zero
    a_ctrl_reserved_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        (rd_in && addr_in == sync_ctrl_pkg::LINK_CTRL_A) |=> rdata_out[7:2] == 6'h00)
        else $error("control unused bits not zero");

    // Code zero carries the CRC value
    a_crc_selected: assert property (@(posedge clock_in) disable iff (rst_in)
        (mb_start_in && link_format_mode_r
         && sync_word_payload_mode_r == sync_ctrl_pkg::PAYLOAD_CRC12)
        |=> sync_word_out[11:0] == $past(crc_in))
        else $error("crc payload not sent");

    // Code two carries the FEC value
    a_fec_selected: assert property (@(posedge clock_in) disable iff (rst_in)
        (mb_start_in && link_format_mode_r
         && sync_word_payload_mode_r == sync_ctrl_pkg::PAYLOAD_FEC)
        |=> sync_word_out[11:0] == $past(fec_in))
        else $error("fec payload not sent");

    // Reserved codes one and three fall back to CRC
    a_reserved_code_crc: assert property (@(posedge clock_in) disable iff (rst_in)
        (mb_start_in && link_format_mode_r && sync_word_payload_mode_r[0])
        |=> sync_word_out[11:0] == $past(crc_in))
        else $error("reserved code not mapped to crc");

    // In 8B/10B formats the mode has no effect
    a_8b10b_no_effect: assert property (@(posedge clock_in) disable iff (rst_in)
        (mb_start_in && !link_format_mode_r) |=> sync_word_out == '0 && !sync_word_valid_out)
        else $error("mode used in 8b10b format");

    // Command fields stay idle
    a_cmd_field_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        sync_word_valid_out
        |-> sync_word_out[sync_ctrl_pkg::CMD_LSB +: sync_ctrl_pkg::CMD_BITS] == '0)
        else $error("command field not idle");

    // Everything above the payload stays zero
    a_word_upper_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        sync_word_valid_out |-> sync_word_out[sync_ctrl_pkg::SYNC_WORD_BITS-1:12] == '0)
        else $error("sync word upper bits not zero");

    // One word per multiblock start
    a_valid_follows_start: assert property (@(posedge clock_in) disable iff (rst_in)
        sync_word_valid_out |-> $past(mb_start_in))
        else $error("sync word without multiblock start");

    // Words only go out enabled and in 64B/66B
    a_valid_needs_enable: assert property (@(posedge clock_in) disable iff (rst_in)
        sync_word_valid_out |-> $past(link_enable_r) && $past(link_format_mode_r))
        else $error("sync word while disabled or 8b10b");
endmodule : sync_ctrl

// ---- rtl/sync_ctrl_pkg.sv ----
// Package: register map, reset values and mode codes of the sync controls
package sync_ctrl_pkg;
    localparam int          ADDR_W           = 10;          // Register address width
    localparam logic [9:0]  SYNC_WORD_MODE_A = 10'h20f;     // Sync word mode select offset
    localparam logic [9:0]  SYNC_REQUEST_LOW_COUNT_A    = 10'h210;     // Sync request threshold offset
    localparam logic [9:0]  LINK_CTRL_A      = 10'h214;     // Link enable and format control
    localparam logic [9:0]  SYNC_STATUS_A    = 10'h215;     // Sync filter status
    localparam logic [7:0]  SYNC_WORD_MODE_RST = 8'h00;     // Default: CRC-12 payload
    localparam logic [7:0]  SYNC_REQUEST_LOW_COUNT_RST  = 8'h03;       // Default: four low samples
    localparam logic [1:0]  PAYLOAD_CRC12    = 2'h0;        // CRC-12 code
    localparam logic [1:0]  PAYLOAD_FEC      = 2'h2;        // FEC code
    localparam int          MODE_LSB         = 0;           // Payload mode field position
    localparam int          THRESH_LSB       = 0;           // Threshold field position
    localparam int          ENABLE_BIT       = 0;           // Link enable bit in control reg
    localparam int          FORMAT_BIT       = 1;           // 64B/66B format bit in control reg
    localparam int          SYNC_WORD_BITS   = 32;          // Sync word data bits per multiblock
    localparam int          CMD_LSB          = 12;          // Command field start in sync word
    localparam int          CMD_BITS         = 7;           // Command field width, always zero
    typedef enum logic [1:0] {
        PAY_CRC,
        PAY_FEC,
        PAY_NONE
    } payload_e;                                            // Effective payload kind
endpackage : sync_ctrl_pkg

// ---- tb/sync_rx_model.sv ----
// Receiver-side model driving the active-low SYNC~ request line
module sync_rx_model (
    input  wire logic       clock_in,
    input  wire logic [5:0] low_len_in,
    input  wire logic       go_in,
    output logic            sync_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] left_r = 6'h00;                  // Low cycles still to drive
    // Only commanded low runs; a commanded run shorter than threshold plus one is an error report
    always_ff @(posedge clock_in) begin
        if (go_in) begin
            left_r <= low_len_in;
        end else if (left_r != 6'h00) begin
            left_r <= left_r - 6'h01;
        end
    end
    // Line idles high, one level per link clock
    assign sync_n_out = (left_r == 6'h00);
endmodule : sync_rx_model

// ---- tb/sync_ctrl_tb.sv ----
// Testbench for the sync word and SYNC~ request filter block
module sync_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, mb = 1'b0;
    logic [9:0]  addr = 10'h000;                 // Register address
    logic [7:0]  wdata = 8'h00, rdata;           // Register data
    logic [5:0]  len = 6'h00;                    // Commanded low run
    logic [11:0] crc = 12'h000, fec = 12'h000;   // Payload sources
    logic [31:0] word;                           // Sync word seen
    logic        sync_n, valid, req, en;         // Design outputs and line
    int          n_fail = 0, tests_run = 0, cyc = 0;
    always #25 clk = ~clk;
    sync_rx_model rx (.clock_in(clk), .low_len_in(len), .go_in(go), .sync_n_out(sync_n));
    sync_ctrl dut (.clock_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sync_n_in(sync_n), .mb_start_in(mb),
        .crc_in(crc), .fec_in(fec), .sync_word_out(word), .sync_word_valid_out(valid),
        .sync_request_out(req), .link_enable_out(en));
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check("rdata", {24'h0, rdata}, {24'h0, exp});
    endtask : rd_reg
    // Settings only touched with the link disabled, reserved bits zero
    task automatic setup(input logic [7:0] mode, input logic [7:0] thr, input logic [7:0] ctl);
        wr_reg(10'h214, 8'h02);
        wr_reg(sync_ctrl_pkg::SYNC_WORD_MODE_A, mode);
        wr_reg(sync_ctrl_pkg::SYNC_REQUEST_LOW_COUNT_A, thr);
        wr_reg(10'h214, ctl);
    endtask : setup
    // Low runs of given lengths, one high cycle between them
    task automatic low_runs(input logic [5:0] a, input logic [5:0] b, output logic seen);
        seen = 1'b0;
        @(posedge clk);
        go <= 1'b1;
        len <= a;
        @(posedge clk);
        go <= 1'b0;
        repeat (a) @(posedge clk);
        // Reload as the first run ends, leaving one high sample between
        go <= (b != 6'h00);
        len <= b;
        @(posedge clk);
        go <= 1'b0;
        repeat (b + 10) begin
            @(posedge clk);
            #1 seen |= (req === 1'b1);
        end
    endtask : low_runs
    task automatic mb_word(input logic [11:0] c, input logic [11:0] f, output logic [31:0] w,
                           output logic v);
        @(posedge clk);
        mb <= 1'b1;
        crc <= c;
        fec <= f;
        @(posedge clk);
        mb <= 1'b0;
        crc <= ~c;
        fec <= ~f;
        #1 w = word;
        v = valid;
    endtask : mb_word
    task automatic t_reset_values;
        rd_reg(sync_ctrl_pkg::SYNC_WORD_MODE_A, 8'h00);
        rd_reg(sync_ctrl_pkg::SYNC_REQUEST_LOW_COUNT_A, 8'h03);
        rd_reg(10'h3ff, 8'h00);
    endtask : t_reset_values
    task automatic t_filter;
        logic s;
        setup(8'h00, 8'h02, 8'h03);
        rd_reg(sync_ctrl_pkg::SYNC_REQUEST_LOW_COUNT_A, 8'h02);
        low_runs(6'd2, 6'd0, s);
        check("short run", {31'h0, s}, 32'h0);
        rd_reg(sync_ctrl_pkg::SYNC_STATUS_A, 8'h05);
        wr_reg(sync_ctrl_pkg::SYNC_STATUS_A, 8'h04);
        rd_reg(sync_ctrl_pkg::SYNC_STATUS_A, 8'h01);
        low_runs(6'd2, 6'd2, s);
        check("broken run", {31'h0, s}, 32'h0);
        low_runs(6'd3, 6'd0, s);
        check("long run", {31'h0, s}, 32'h1);
        setup(8'h00, 8'h00, 8'h02);
        low_runs(6'd1, 6'd0, s);
        check("disabled low", {31'h0, s}, 32'h0);
        check("enable off", {31'h0, en}, 32'h0);
        setup(8'h00, 8'h00, 8'h03);
        low_runs(6'd1, 6'd0, s);
        check("single low", {31'h0, s}, 32'h1);
    endtask : t_filter
    task automatic t_word;
        logic [31:0] w;
        logic        v;
        setup(8'h00, 8'h03, 8'h03);
        mb_word(12'ha5c, 12'h3e1, w, v);
        check("crc word", {w[31:1], v}, {20'h0, 12'ha5c} | 32'h1);
        check("crc bits", w, {20'h0, 12'ha5c});
        check("link enable", {31'h0, en}, 32'h1);
        setup(8'h01, 8'h03, 8'h03);
        mb_word(12'h5a5, 12'h0ff, w, v);
        check("reserved code", w, {20'h0, 12'h5a5});
        setup(8'h02, 8'h03, 8'h03);
        mb_word(12'h0f0, 12'hc3b, w, v);
        check("fec word", w, {20'h0, 12'hc3b});
        check("fec valid", {31'h0, v}, 32'h1);
        setup(8'h02, 8'h03, 8'h01);
        mb_word(12'h111, 12'h222, w, v);
        check("8b10b valid", {31'h0, v}, 32'h0);
        check("8b10b word", w, 32'h0);
    endtask : t_word
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_filter();
        t_word();
        give_verdict();
    end
endmodule : sync_ctrl_tb
